// ===== tpadc_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpadc_params.svh"
module tpadc_core
  import tpadc_pkg::*;
(
  // core clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  // serial link pins
  input  wire logic                     serial_conv_clock,
  input  wire logic                     cs_n,
  input  wire logic                     din,
  output logic                          dout,
  output logic                          dout_oe,
  output logic                          busy,
  output logic                          busy_oe,
  // touch interrupt pin, open drain
  output logic                          touch_irq_n_out,
  output logic                          touch_irq_n_oe,
  // touch sense from the panel
  input  wire logic                     touch_sense,
  // control words toward the converter
  output logic                          conv_req_valid,
  input  wire logic                     conv_req_ready,
  output logic [`TPADC_CTRL_W-1:0]      conv_req_data,
  // results from the converter
  input  wire logic                     conv_res_valid,
  input  wire logic [`TPADC_RES_W-1:0]  conv_res_data,
  // status
  output logic                          power_mgmt_hi,
  output logic                          power_mgmt_lo,
  output logic                          touch_detect_enabled
);
  // ==========================================================
  // link domain declarations
  logic                     link_rst_n;
  logic [3:0]               edge_cnt;
  logic [2:0]               hold_cnt;
  logic [5:0]               shreg;
  logic [`TPADC_CTRL_W-1:0] ctrl;
  logic [`TPADC_CTRL_W-1:0] next_ctrl;
  logic                     start_seen;
  logic                     word_done;
  logic [3:0]               bits_left;
  logic [`TPADC_RES_W-1:0]  res_copy;
  logic                     start_tgl;
  logic                     req_tgl;
  logic                     rel_tgl;
  logic                     eoc_tgl;
  logic                     ack_s1;
  logic                     ack_s2;
  logic                     ack_seen;

  // ==========================================================
  // core domain declarations
  tpadc_state_type          state;
  logic [2:0]               start_sy;
  logic [2:0]               req_sy;
  logic [2:0]               rel_sy;
  logic [2:0]               eoc_sy;
  logic [2:0]               cs_sy;
  logic [1:0]               touch_sy;
  logic                     req_taken;
  logic                     ack_tgl;
  logic [`TPADC_RES_W-1:0]  res_hold;
  logic [1:0]               pm_code;
  logic                     pen_en;
  logic                     irq_low;
  logic                     buf_in_valid;
  logic                     buf_in_ready;
  logic                     start_ev;
  logic                     rel_ev;
  logic                     eoc_ev;
  logic                     cs_rise_ev;
  logic                     req_pending;

  // ==========================================================
  // chip select high holds the link logic idle
  assign link_rst_n = reset_n && !cs_n;
  assign dout_oe    = !cs_n;
  assign busy_oe    = !cs_n;

  // ==========================================================
  // start detection and control word load, rising edges
  assign start_seen = (edge_cnt == 4'h0) && (hold_cnt == 3'h0) && din;
  assign word_done  = (edge_cnt == `TPADC_LOAD_EDGE);
  assign next_ctrl  = {shreg, din};

  always_ff @(posedge serial_conv_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      edge_cnt <= 4'h0;
      shreg    <= 6'h00;
    end else begin
      if (start_seen) begin
        edge_cnt <= 4'h1;
      end else if (edge_cnt == `TPADC_WORD_EDGE) begin
        edge_cnt <= 4'h0;
      end else if (edge_cnt != 4'h0) begin
        edge_cnt <= edge_cnt + 4'h1;
        shreg    <= {shreg[4:0], din};
      end
    end
  end

  // start lockout after each loaded word
  always_ff @(posedge serial_conv_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      hold_cnt <= 3'h0;
    end else if (word_done) begin
      hold_cnt <= next_ctrl[`TPADC_MODE_BIT] ? `TPADC_HOLD_8 : `TPADC_HOLD_12;
    end else if (hold_cnt != 3'h0) begin
      hold_cnt <= hold_cnt - 3'h1;
    end
  end

  // control word survives chip select, cleared only by power-up
  always_ff @(posedge serial_conv_clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= `TPADC_CTRL_RESET;
    end else if (word_done && !cs_n) begin
      ctrl <= next_ctrl;
    end
  end

  // event toggles toward the core domain
  always_ff @(posedge serial_conv_clock or negedge reset_n) begin
    if (!reset_n) begin
      start_tgl <= 1'b0;
      req_tgl   <= 1'b0;
    end else begin
      if (start_seen && !cs_n) begin
        start_tgl <= !start_tgl;
      end
      if (word_done && !cs_n) begin
        req_tgl <= !req_tgl;
      end
    end
  end

  // ==========================================================
  // result handshake back into the link domain
  always_ff @(negedge serial_conv_clock or negedge reset_n) begin
    if (!reset_n) begin
      ack_s1   <= 1'b0;
      ack_s2   <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      ack_s1   <= ack_tgl;
      ack_s2   <= ack_s1;
      // a new result waits until the current word has shifted out
      if (bits_left == 4'h0) begin
        ack_seen <= ack_s2;
      end
    end
  end

  always_ff @(negedge serial_conv_clock or negedge reset_n) begin
    if (!reset_n) begin
      res_copy <= '0;
    end else if (ack_s2 != ack_seen && bits_left == 4'h0) begin
      res_copy <= res_hold;
    end
  end

  // ==========================================================
  // busy, data shifting and conversion end, falling edges
  always_ff @(negedge serial_conv_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      busy      <= 1'b0;
      dout      <= 1'b0;
      bits_left <= 4'h0;
    end else begin
      busy <= (edge_cnt == `TPADC_WORD_EDGE);
      if (edge_cnt == `TPADC_WORD_EDGE) begin
        dout      <= 1'b0;
        bits_left <= ctrl[`TPADC_MODE_BIT] ? `TPADC_BITS_8 : `TPADC_BITS_12;
      end else if (bits_left != 4'h0) begin
        dout      <= res_copy[bits_left - 4'h1];
        bits_left <= bits_left - 4'h1;
      end else begin
        dout <= 1'b0;
      end
    end
  end

  // release and conversion end events
  always_ff @(negedge serial_conv_clock or negedge reset_n) begin
    if (!reset_n) begin
      rel_tgl <= 1'b0;
      eoc_tgl <= 1'b0;
    end else begin
      if (edge_cnt == `TPADC_RELEASE_EDGE && !cs_n) begin
        rel_tgl <= !rel_tgl;
      end
      if (bits_left == 4'h1 && edge_cnt == 4'h0 && !cs_n) begin
        eoc_tgl <= !eoc_tgl;
      end
    end
  end

  // ==========================================================
  // synchronisers into the core domain, one per event
  // start toggle, third stage feeds the edge compare
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      start_sy <= 3'h0;
    end else begin
      start_sy <= {start_sy[1:0], start_tgl};
    end
  end

  // control word toggle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_sy <= 3'h0;
    end else begin
      req_sy <= {req_sy[1:0], req_tgl};
    end
  end

  // release toggle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rel_sy <= 3'h0;
    end else begin
      rel_sy <= {rel_sy[1:0], rel_tgl};
    end
  end

  // conversion end toggle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      eoc_sy <= 3'h0;
    end else begin
      eoc_sy <= {eoc_sy[1:0], eoc_tgl};
    end
  end

  // chip select level, idles high so reset shows no false rise
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_sy <= 3'h7;
    end else begin
      cs_sy <= {cs_sy[1:0], cs_n};
    end
  end

  // panel touch level
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      touch_sy <= 2'h0;
    end else begin
      touch_sy <= {touch_sy[0], touch_sense};
    end
  end

  assign start_ev    = start_sy[2] != start_sy[1];
  assign rel_ev      = rel_sy[2] != rel_sy[1];
  assign eoc_ev      = eoc_sy[2] != eoc_sy[1];
  assign cs_rise_ev  = cs_sy[1] && !cs_sy[2];
  assign req_pending = req_sy[1] != req_taken;

  // ==========================================================
  // request and result sequencing
  assign buf_in_valid = (state == TPADC_IDLE) && req_pending;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= TPADC_IDLE;
      req_taken <= 1'b0;
      ack_tgl   <= 1'b0;
      res_hold  <= '0;
    end else begin
      case (state)
        TPADC_IDLE: begin
          if (req_pending && buf_in_ready) begin
            req_taken <= req_sy[1];
            state     <= TPADC_WAIT;
          end
        end
        TPADC_WAIT: begin
          if (conv_res_valid) begin
            res_hold <= conv_res_data;
            ack_tgl  <= !ack_tgl;
            state    <= TPADC_IDLE;
          end
        end
        default: begin
          state <= TPADC_IDLE;
        end
      endcase
    end
  end

  // power setting copied when a word is accepted
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pm_code <= 2'h0;
    end else if (buf_in_valid && buf_in_ready) begin
      pm_code <= {ctrl[`TPADC_PM_HI_BIT], ctrl[`TPADC_PM_LO_BIT]};
    end
  end

  assign power_mgmt_hi = pm_code[1];
  assign power_mgmt_lo = pm_code[0];

  // ==========================================================
  // touch detection enable
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pen_en <= 1'b1;
    end else if (start_ev) begin
      pen_en <= 1'b0;
    end else if (eoc_ev || cs_rise_ev) begin
      pen_en <= (pm_code != `TPADC_PM_IRQ_OFF);
    end
  end

  // interrupt pull-down, held until the fourth falling edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_low <= 1'b0;
    end else if (rel_ev) begin
      irq_low <= 1'b0;
    end else if (pen_en && touch_sy[1]) begin
      irq_low <= 1'b1;
    end else if (pen_en) begin
      irq_low <= 1'b0;
    end
  end

  assign touch_irq_n_out      = 1'b0;
  assign touch_irq_n_oe       = irq_low;
  assign touch_detect_enabled = pen_en;

  // ==========================================================
  // control word buffer toward the converter
  tpadc_buf2 #(
    .WIDTH (`TPADC_CTRL_W),
    .DEPTH (`TPADC_BUF_DEPTH)
  ) u_buf (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (ctrl),
    .out_valid (conv_req_valid),
    .out_ready (conv_req_ready),
    .out_data  (conv_req_data)
  );
endmodule
`default_nettype wire

// ===== tpadc_params.svh
`ifndef TPADC_PARAMS_SVH
`define TPADC_PARAMS_SVH

// ==========================================================
// control word layout (seven bits after the start bit)
`define TPADC_CTRL_W        7
`define TPADC_CHAN_HI       6
`define TPADC_CHAN_LO       4
`define TPADC_MODE_BIT      3
`define TPADC_REF_BIT       2
`define TPADC_PM_HI_BIT     1
`define TPADC_PM_LO_BIT     0
`define TPADC_CTRL_RESET    7'h00

// ==========================================================
// framing counts in serial clocks
`define TPADC_LOAD_EDGE     4'h7
`define TPADC_WORD_EDGE     4'h8
`define TPADC_RELEASE_EDGE  4'h4
`define TPADC_HOLD_12       3'h7
`define TPADC_HOLD_8        3'h3
`define TPADC_BITS_12       4'hc
`define TPADC_BITS_8        4'h8
`define TPADC_RES_W         12

// ==========================================================
// power management codes
`define TPADC_PM_IRQ_OFF    2'h1

// ==========================================================
// request buffer
`define TPADC_BUF_DEPTH     2

`endif

// ===== tpadc_pkg.sv
`default_nettype none
package tpadc_pkg;
  typedef enum logic [1:0] {
    TPADC_IDLE = 2'h1,
    TPADC_WAIT = 2'h2
  } tpadc_state_type;
endpackage
`default_nettype wire

// ===== tpadc_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module tpadc_buf2 #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // ==========================================================
  // handshakes
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // ==========================================================
  // storage
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ===== tpadc_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker
module tpadc_core_asserts (
  // clocks and reset
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       serial_conv_clock,
  // link pins
  input wire logic       cs_n,
  input wire logic       dout_oe,
  input wire logic       busy,
  input wire logic       busy_oe,
  // touch interrupt
  input wire logic       touch_irq_n_out,
  input wire logic       touch_irq_n_oe,
  input wire logic       touch_sense,
  // status and requests
  input wire logic       power_mgmt_hi,
  input wire logic       power_mgmt_lo,
  input wire logic       touch_detect_enabled,
  input wire logic       conv_req_valid,
  input wire logic       conv_req_ready,
  input wire logic [6:0] conv_req_data
);
  property p_irq_low_only;
    @(posedge core_clk) disable iff (!reset_n) touch_irq_n_oe |-> touch_irq_n_out == 1'b0;
  endproperty
  a_irq_low_only: assert property (p_irq_low_only) else $error("irq driven high");
  property p_irq_on_touch;
    @(posedge core_clk) disable iff (!reset_n)
      (touch_sense && touch_detect_enabled) [*4] |-> touch_irq_n_oe;
  endproperty
  a_irq_on_touch: assert property (p_irq_on_touch) else $error("touch not flagged");
  property p_irq_needs_enable;
    @(posedge core_clk) disable iff (!reset_n) $rose(touch_irq_n_oe) |-> $past(touch_detect_enabled);
  endproperty
  a_irq_needs_enable: assert property (p_irq_needs_enable) else $error("irq while off");
  property p_no_new_irq;
    @(posedge core_clk) disable iff (!reset_n)
      !touch_detect_enabled && !touch_irq_n_oe |=> !touch_irq_n_oe;
  endproperty
  a_no_new_irq: assert property (p_no_new_irq) else $error("irq after disable");
  property p_reset_enabled;
    @(posedge core_clk) disable iff (!reset_n) $rose(reset_n) |-> touch_detect_enabled;
  endproperty
  a_reset_enabled: assert property (p_reset_enabled) else $error("detect off at reset");
  property p_oe_tracks_cs;
    @(posedge core_clk) disable iff (!reset_n) dout_oe == !cs_n && busy_oe == !cs_n;
  endproperty
  a_oe_tracks_cs: assert property (p_oe_tracks_cs) else $error("oe vs select");
  property p_busy_one;
    @(negedge serial_conv_clock) disable iff (!reset_n) busy |=> !busy;
  endproperty
  a_busy_one: assert property (p_busy_one) else $error("busy too long");
  property p_stay_off_code01;
    @(posedge core_clk) disable iff (!reset_n)
      !touch_detect_enabled && !power_mgmt_hi && power_mgmt_lo |=> !touch_detect_enabled;
  endproperty
  a_stay_off_code01: assert property (p_stay_off_code01) else $error("code 01 enabled");
  property p_hold_off;
    @(posedge core_clk) disable iff (!reset_n)
      $fell(touch_irq_n_oe) && !touch_detect_enabled |=> !touch_detect_enabled [*8];
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("early re-enable");
  property p_stall_hold;
    @(posedge core_clk) disable iff (!reset_n)
      conv_req_valid && !conv_req_ready |=> conv_req_valid && $stable(conv_req_data);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("word lost");
endmodule
bind tpadc_core tpadc_core_asserts chk (
  .core_clk(core_clk), .reset_n(reset_n), .serial_conv_clock(serial_conv_clock),
  .cs_n(cs_n), .dout_oe(dout_oe), .busy(busy), .busy_oe(busy_oe),
  .touch_irq_n_out(touch_irq_n_out), .touch_irq_n_oe(touch_irq_n_oe),
  .touch_sense(touch_sense), .power_mgmt_hi(power_mgmt_hi),
  .power_mgmt_lo(power_mgmt_lo), .touch_detect_enabled(touch_detect_enabled),
  .conv_req_valid(conv_req_valid), .conv_req_ready(conv_req_ready),
  .conv_req_data(conv_req_data)
);
`default_nettype wire

// ===== tpadc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host serial controller
module tpadc_host (
  // link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  // observed pins
  input  wire logic dout,
  input  wire logic busy,
  input  wire logic irq
);
  logic [63:0] rx_dout;
  logic [63:0] rx_busy;
  logic [63:0] rx_irq;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // n clocks, msb first; clock rests low outside frames
  task automatic frame(input logic [63:0] bits, input int n);
    cs_n = 1'b0;
    #50;
    for (int i = n - 1; i >= 0; i--) begin
      din = bits[i];
      #62.5;
      sclk = 1'b1;
      rx_dout = {rx_dout[62:0], dout};
      rx_busy = {rx_busy[62:0], busy};
      rx_irq = {rx_irq[62:0], irq};
      #62.5;
      sclk = 1'b0;
    end
    #50;
    cs_n = 1'b1;
    din = ~din;
  endtask
endmodule
`default_nettype wire

// ===== tpadc_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tpadc_core_tb;
  // ==========================================================
  // signals
  logic        core_clk;
  logic        reset_n;
  logic        sclk;
  logic        cs_n;
  logic        din;
  logic        dout;
  logic        dout_oe;
  logic        busy;
  logic        busy_oe;
  logic        dout_line;
  logic        busy_line;
  logic        irq_out;
  logic        irq_oe;
  logic        touch_irq_n;
  logic        touch_sense;
  logic        req_valid;
  logic        req_ready;
  logic [6:0]  req_data;
  logic [6:0]  last_req;
  logic        res_valid;
  logic        took;
  logic [11:0] res_val;
  logic        pm_hi;
  logic        pm_lo;
  logic        det_en;
  int          err_total;
  int          compares;
  // ==========================================================
  // design, host and converter
  tpadc_core uut (
    .core_clk(core_clk), .reset_n(reset_n), .serial_conv_clock(sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .dout_oe(dout_oe), .busy(busy), .busy_oe(busy_oe),
    .touch_irq_n_out(irq_out), .touch_irq_n_oe(irq_oe), .touch_sense(touch_sense),
    .conv_req_valid(req_valid), .conv_req_ready(req_ready), .conv_req_data(req_data),
    .conv_res_valid(res_valid), .conv_res_data(res_val), .power_mgmt_hi(pm_hi),
    .power_mgmt_lo(pm_lo), .touch_detect_enabled(det_en)
  );
  tpadc_host host (
    .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_line), .busy(busy_line),
    .irq(touch_irq_n)
  );
  assign touch_irq_n = irq_oe ? irq_out : 1'b1;
  // a released pin reads high, the inverse of its output held low by the link reset
  assign dout_line   = dout_oe ? dout : !dout;
  assign busy_line   = busy_oe ? busy : !busy;
  always @(negedge core_clk) begin
    took <= req_valid && req_ready;
    res_valid <= took;
  end
  always @(posedge core_clk) begin
    if (req_valid && req_ready) begin
      last_req <= req_data;
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ==========================================================
  // helpers
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [6:0] word(input logic mode, input logic [1:0] pm);
    return {3'h1, mode, 1'b0, pm};
  endfunction
  task automatic go(input logic [63:0] bits, input int n);
    @(negedge core_clk);
    host.frame(bits, n);
    repeat (8) @(negedge core_clk);
  endtask
  task automatic print_verdict;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_touch;
    check(12'(det_en), 12'h001);
    touch_sense = 1'b1;
    repeat (6) @(negedge core_clk);
    check(12'(touch_irq_n), 12'h000);
    go(64'({1'b1, word(1'b0, 2'h0), 16'h0}), 24);
    check(12'(host.rx_irq[20]), 12'h000);
    check(12'(host.rx_irq[17]), 12'h001);
    check(12'(host.rx_irq[8]), 12'h001);
    check(12'({det_en, touch_irq_n}), 12'h002);
    touch_sense = 1'b0;
    repeat (6) @(negedge core_clk);
    check(12'(touch_irq_n), 12'h001);
  endtask
  task automatic t_codes;
    go(64'({1'b1, word(1'b0, 2'h1), 16'h0}), 24);
    touch_sense = 1'b1;
    repeat (8) @(negedge core_clk);
    check(12'({det_en, touch_irq_n}), 12'h001);
    go(64'({1'b1, word(1'b0, 2'h2), 16'h0}), 24);
    check(12'({det_en, touch_irq_n, pm_hi, pm_lo}), 12'h00a);
    go(64'({1'b1, word(1'b0, 2'h0), 4'h0}), 12);
    check(12'({dout_oe, busy_oe, det_en}), 12'h001);
  endtask
  task automatic t_overlap;
    go(64'({1'b1, word(1'b0, 2'h0), 7'h0, 1'b1, word(1'b0, 2'h2), 16'h0}), 39);
    check(host.rx_dout[29:18], res_val);
    check(host.rx_dout[14:3], res_val);
    check(host.rx_busy[38:27], 12'h008);
    check(host.rx_busy[26:15], 12'h001);
    check(host.rx_irq[26:15], 12'hfff);
    check(12'(last_req), 12'h012);
    touch_sense = 1'b0;
  endtask
  task automatic t_refused;
    go(64'({1'b1, word(1'b0, 2'h0), 7'h7f, 9'h0}), 24);
    check(host.rx_busy[23:12], 12'h008);
    check(host.rx_busy[11:0], 12'h000);
  endtask
  task automatic t_short;
    res_val = 12'haaa;
    go(64'({1'b1, word(1'b1, 2'h0), 16'h0}), 24);
    go(64'({1'b1, word(1'b1, 2'h0), 3'h0, 1'b1, word(1'b1, 2'h0), 9'h0}), 28);
    check(host.rx_busy[27:16], 12'h008);
    check(host.rx_busy[15:4], 12'h010);
    check(12'(host.rx_dout[18:11]), 12'h0aa);
    check(12'(host.rx_dout[7:0]), 12'h0aa);
  endtask
  task automatic t_stall;
    req_ready = 1'b0;
    go(64'({1'b1, word(1'b0, 2'h0), 16'h0}), 24);
    go(64'({1'b1, word(1'b0, 2'h2), 16'h0}), 24);
    check(12'({req_valid, req_data}), 12'h090);
    req_ready = 1'b1;
    repeat (20) @(negedge core_clk);
    check(12'(last_req), 12'h012);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    reset_n = 1'b0;
    touch_sense = 1'b0;
    req_ready = 1'b1;
    res_val = 12'h5a3;
    err_total = 0;
    compares = 0;
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge core_clk);
    t_touch;
    t_codes;
    touch_sense = 1'b1;
    t_overlap;
    t_refused;
    t_short;
    t_stall;
    print_verdict;
  end
  initial begin
    #500000;
    err_total++;
    print_verdict;
  end
endmodule
`default_nettype wire
